/* File: hw/pwgt_gate.sv */
// protected write gate, erased and invalid read patterns and fault trapping
//
// How it works
// - protected writes pass only while the issuer's open flag is set.
// - cpu and dma share one flag; the coprocessor owns its own flag.
// - open instruction sets the owner's flag, close instruction clears it.
// - reads of protected registers always pass, whatever the flags.
// - reads of invalid addresses return all zeros.
// - reads of erased flash return all ones, unless the address is also invalid (then zeros).
// - cpu fetch of all-zeros or all-ones word raises the illegal opcode trap.
// - cpu underflow, overflow and illegal operation raise diagnostics.
// - coprocessor illegal opcode or fp underflow/overflow interrupts the cpu.
// - coprocessor fetch of all-zeros or all-ones word interrupts the cpu.
// - coprocessor keeps cause flags the cpu reads to find the fault.
`timescale 1ns/1ps
`default_nettype none
module pwgt_gate
  import pwgt_pkg::*;
(
  // clock and reset
  input wire logic core_clk_i,
  input wire logic resetn_i,
  // protection instructions
  input wire logic cpu_protect_write_open_i,
  input wire logic cpu_protect_write_close_i,
  input wire logic coproc_protect_write_open_i,
  input wire logic coproc_protect_write_close_i,
  // access request toward protected space
  input wire logic req_valid_i,
  input wire logic req_write_i,
  input wire logic req_protected_i,
  input wire pwgt_src_t req_src_i,
  input wire logic req_invalid_addr_i,
  input wire logic req_erased_flash_i,
  input wire logic [31:0] mem_rdata_i,
  // access result
  output logic acc_pass_o,
  output logic acc_blocked_o,
  output logic [31:0] rdata_o,
  output logic rvalid_o,
  // cpu fetch and execute
  input wire logic cpu_fetch_valid_i,
  input wire logic [31:0] cpu_fetch_word_i,
  input wire logic cpu_underflow_i,
  input wire logic cpu_overflow_i,
  input wire logic cpu_illegal_op_i,
  output logic illegal_opcode_trap_o,
  output logic [2:0] cpu_diag_o,
  // coprocessor fetch and execute
  input wire logic cop_fetch_valid_i,
  input wire logic [31:0] cop_fetch_word_i,
  input wire logic cop_illegal_op_i,
  input wire logic cop_underflow_i,
  input wire logic cop_overflow_i,
  input wire logic cop_cause_clear_i,
  output logic cop_irq_o,
  output logic [3:0] cop_cause_o,
  // flag status
  output logic cpu_open_o,
  output logic cop_open_o
);

  logic cpu_open_ff;
  logic cop_open_ff;
  logic [3:0] cause_ff;
  logic [3:0] nxt_cause;
  logic [3:0] cause_set;
  logic req_flag;

  function automatic logic pwgt_bad_word(input logic [31:0] w);
    pwgt_bad_word = (w == PWGT_ZERO_WORD) || (w == PWGT_ONES_WORD);
  endfunction

  // open wins over close when both arrive together
  always_ff @(posedge core_clk_i) begin
    if (!resetn_i) begin
      cpu_open_ff <= PWGT_FLAG_RST;
    end else if (cpu_protect_write_open_i) begin
      cpu_open_ff <= 1'b1;
    end else if (cpu_protect_write_close_i) begin
      cpu_open_ff <= 1'b0;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!resetn_i) begin
      cop_open_ff <= PWGT_FLAG_RST;
    end else if (coproc_protect_write_open_i) begin
      cop_open_ff <= 1'b1;
    end else if (coproc_protect_write_close_i) begin
      cop_open_ff <= 1'b0;
    end
  end

  // dma rides on the cpu flag, coprocessor on its own
  always_comb begin
    case (req_src_i)
      PWGT_SRC_CPU: req_flag = cpu_open_ff;
      PWGT_SRC_DMA: req_flag = cpu_open_ff;
      PWGT_SRC_COPROC: req_flag = cop_open_ff;
      default: req_flag = 1'b0;
    endcase
  end

  always_ff @(posedge core_clk_i) begin
    if (!resetn_i) begin
      acc_pass_o <= 1'b0;
      acc_blocked_o <= 1'b0;
    end else begin
      // reads and unprotected writes always pass
      acc_pass_o <= req_valid_i && (!req_write_i || !req_protected_i || req_flag);
      acc_blocked_o <= req_valid_i && req_write_i && req_protected_i && !req_flag;
    end
  end

  // invalid address outranks erased flash
  always_ff @(posedge core_clk_i) begin
    if (!resetn_i) begin
      rdata_o <= PWGT_ZERO_WORD;
      rvalid_o <= 1'b0;
    end else begin
      rvalid_o <= req_valid_i && !req_write_i;
      if (req_invalid_addr_i) begin
        rdata_o <= PWGT_ZERO_WORD;
      end else if (req_erased_flash_i) begin
        rdata_o <= PWGT_ONES_WORD;
      end else begin
        rdata_o <= mem_rdata_i;
      end
    end
  end

  // one-cycle pulses; software handlers latch them as needed
  always_ff @(posedge core_clk_i) begin
    if (!resetn_i) begin
      illegal_opcode_trap_o <= 1'b0;
      cpu_diag_o <= PWGT_DIAG_RST;
    end else begin
      illegal_opcode_trap_o <= cpu_fetch_valid_i && pwgt_bad_word(cpu_fetch_word_i);
      cpu_diag_o[PWGT_DIAG_ILLOP] <= cpu_illegal_op_i;
      cpu_diag_o[PWGT_DIAG_UFL] <= cpu_underflow_i;
      cpu_diag_o[PWGT_DIAG_OFL] <= cpu_overflow_i;
    end
  end

  always_comb begin
    cause_set = PWGT_CAUSE_RST;
    cause_set[PWGT_CAUSE_ILL] = cop_illegal_op_i;
    cause_set[PWGT_CAUSE_UFL] = cop_underflow_i;
    cause_set[PWGT_CAUSE_OFL] = cop_overflow_i;
    cause_set[PWGT_CAUSE_BADW] = cop_fetch_valid_i && pwgt_bad_word(cop_fetch_word_i);
    // set beats clear so a fault in the clear cycle survives
    nxt_cause = (cop_cause_clear_i ? PWGT_CAUSE_RST : cause_ff) | cause_set;
  end

  always_ff @(posedge core_clk_i) begin
    if (!resetn_i) begin
      cause_ff <= PWGT_CAUSE_RST;
    end else begin
      cause_ff <= nxt_cause;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!resetn_i) begin
      cop_irq_o <= 1'b0;
      cop_cause_o <= PWGT_CAUSE_RST;
      cpu_open_o <= 1'b0;
      cop_open_o <= 1'b0;
    end else begin
      cop_irq_o <= |nxt_cause;
      cop_cause_o <= nxt_cause;
      cpu_open_o <= cpu_open_ff;
      cop_open_o <= cop_open_ff;
    end
  end

  AST_BLOCK_CLOSED: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
    req_valid_i && req_write_i && req_protected_i && !req_flag |=> acc_blocked_o && !acc_pass_o)
    else $error("protected write passed while flag closed");

  AST_PASS_OPEN: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
    req_valid_i && req_write_i && req_protected_i && req_flag |=> acc_pass_o && !acc_blocked_o)
    else $error("protected write blocked while flag open");

  AST_DMA_SHARES: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
    req_valid_i && req_write_i && req_protected_i && req_src_i == PWGT_SRC_DMA
    |=> acc_pass_o == cpu_open_o)
    else $error("dma write not governed by cpu flag");

  AST_OPEN_SETS: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
    coproc_protect_write_open_i |=> ##1 cop_open_o)
    else $error("coprocessor open did not set flag");

  AST_CLOSE_CLEARS: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
    cpu_protect_write_close_i && !cpu_protect_write_open_i |=> ##1 !cpu_open_o)
    else $error("cpu close did not clear flag");

  AST_READ_PASS: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
    req_valid_i && !req_write_i |=> acc_pass_o && rvalid_o)
    else $error("read was blocked");

  AST_ZERO_DATA: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
    req_invalid_addr_i |=> rdata_o == PWGT_ZERO_WORD)
    else $error("invalid address did not read zero");

  AST_ONES_DATA: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
    !req_invalid_addr_i && req_erased_flash_i |=> rdata_o == PWGT_ONES_WORD)
    else $error("erased flash did not read ones");

  AST_TRAP: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
    illegal_opcode_trap_o |-> $past(cpu_fetch_valid_i) && pwgt_bad_word($past(cpu_fetch_word_i)))
    else $error("trap without bad fetch word");

  AST_CPU_DIAG: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
    cpu_overflow_i |=> cpu_diag_o[PWGT_DIAG_OFL])
    else $error("cpu overflow diagnostic missing");

  AST_COP_IRQ: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
    cop_illegal_op_i |=> cop_irq_o && cop_cause_o[PWGT_CAUSE_ILL])
    else $error("coprocessor illegal opcode did not interrupt");

  AST_COP_BADW: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
    cop_fetch_valid_i && cop_fetch_word_i == PWGT_ONES_WORD |=> cop_cause_o[PWGT_CAUSE_BADW])
    else $error("coprocessor bad word fetch not flagged");

  AST_CAUSE_STICKY: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
    cop_cause_o[PWGT_CAUSE_UFL] && !cop_cause_clear_i |=> cop_cause_o[PWGT_CAUSE_UFL])
    else $error("cause flag lost without clear");

  AST_RESET_CLOSED: assert property (@(posedge core_clk_i)
    !resetn_i |=> ##1 !cpu_open_o && !cop_open_o)
    else $error("flags not closed after reset");

  // reverse checks: a broken path must also show up on its quiet side
  AST_CPU_OPEN_SETS: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
    cpu_protect_write_open_i |=> ##1 cpu_open_o)
    else $error("cpu open did not set flag");

  AST_COP_CLOSE_CLEARS: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
    coproc_protect_write_close_i && !coproc_protect_write_open_i |=> ##1 !cop_open_o)
    else $error("coprocessor close did not clear flag");

  AST_COP_OWN_FLAG: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
    req_valid_i && req_write_i && req_protected_i && req_src_i == PWGT_SRC_COPROC
    |=> acc_pass_o == cop_open_o)
    else $error("coprocessor write not governed by its own flag");

  AST_NO_READ_BLOCK: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
    req_valid_i && !req_write_i |=> !acc_blocked_o)
    else $error("read reported as blocked");

  AST_BLOCK_WRITES: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
    acc_blocked_o |-> $past(req_valid_i) && $past(req_write_i) && $past(req_protected_i))
    else $error("block without protected write");

  AST_PASS_XOR_BLOCK: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
    !(acc_pass_o && acc_blocked_o))
    else $error("access both passed and blocked");

  AST_TRAP_FIRES: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
    cpu_fetch_valid_i && pwgt_bad_word(cpu_fetch_word_i) |=> illegal_opcode_trap_o)
    else $error("bad fetch word did not trap");

  AST_TRAP_QUIET: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
    !(cpu_fetch_valid_i && pwgt_bad_word(cpu_fetch_word_i)) |=> !illegal_opcode_trap_o)
    else $error("trap without bad fetch word");

  AST_DIAG_UFL: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
    cpu_underflow_i |=> cpu_diag_o[PWGT_DIAG_UFL])
    else $error("cpu underflow diagnostic missing");

  AST_DIAG_ILL: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
    cpu_illegal_op_i |=> cpu_diag_o[PWGT_DIAG_ILLOP])
    else $error("cpu illegal operation diagnostic missing");

  AST_DIAG_QUIET: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
    !cpu_overflow_i |=> !cpu_diag_o[PWGT_DIAG_OFL])
    else $error("cpu overflow diagnostic without overflow");

  AST_COP_UFL_IRQ: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
    cop_underflow_i |=> cop_irq_o && cop_cause_o[PWGT_CAUSE_UFL])
    else $error("coprocessor underflow did not interrupt");

  AST_COP_OFL_IRQ: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
    cop_overflow_i |=> cop_irq_o && cop_cause_o[PWGT_CAUSE_OFL])
    else $error("coprocessor overflow did not interrupt");

  AST_IRQ_STICKY: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
    cop_irq_o && !cop_cause_clear_i |=> cop_irq_o)
    else $error("coprocessor interrupt dropped without clear");

  AST_COP_ZERO_WORD: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
    cop_fetch_valid_i && cop_fetch_word_i == PWGT_ZERO_WORD
    |=> cop_irq_o && cop_cause_o[PWGT_CAUSE_BADW])
    else $error("coprocessor zero word fetch not flagged");

  AST_BADW_CAUSE: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
    $rose(cop_cause_o[PWGT_CAUSE_BADW]) |-> $past(cop_fetch_valid_i)
    && pwgt_bad_word($past(cop_fetch_word_i)))
    else $error("bad word cause without bad fetch");

  AST_BADW_STICKY: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
    cop_cause_o[PWGT_CAUSE_BADW] && !cop_cause_clear_i |=> cop_cause_o[PWGT_CAUSE_BADW])
    else $error("bad word cause lost without clear");

  AST_CAUSE_CLEAR: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
    cop_cause_clear_i && !cop_illegal_op_i && !cop_underflow_i && !cop_overflow_i
    && !(cop_fetch_valid_i && pwgt_bad_word(cop_fetch_word_i))
    |=> cop_cause_o == PWGT_CAUSE_RST && !cop_irq_o)
    else $error("cause flags not cleared");

endmodule // pwgt_gate
`default_nettype wire

/* File: hw/pwgt_pkg.sv */
// shared constants for the protected write gate and fault trap block
package pwgt_pkg;
  localparam int unsigned PWGT_DW = 32;
  localparam logic [31:0] PWGT_ZERO_WORD = 32'h0000_0000;
  localparam logic [31:0] PWGT_ONES_WORD = 32'hffff_ffff;
  localparam logic PWGT_FLAG_RST = 1'b0;
  // coprocessor cause flag positions
  localparam int unsigned PWGT_CAUSE_W = 4;
  localparam int unsigned PWGT_CAUSE_ILL = 0;
  localparam int unsigned PWGT_CAUSE_UFL = 1;
  localparam int unsigned PWGT_CAUSE_OFL = 2;
  localparam int unsigned PWGT_CAUSE_BADW = 3;
  localparam logic [3:0] PWGT_CAUSE_RST = 4'h0;
  // main processor diagnostic bit positions
  localparam int unsigned PWGT_DIAG_W = 3;
  localparam int unsigned PWGT_DIAG_ILLOP = 0;
  localparam int unsigned PWGT_DIAG_UFL = 1;
  localparam int unsigned PWGT_DIAG_OFL = 2;
  localparam logic [2:0] PWGT_DIAG_RST = 3'h0;
  typedef enum logic [1:0] {
    PWGT_SRC_CPU,
    PWGT_SRC_DMA,
    PWGT_SRC_COPROC
  } pwgt_src_t;
endpackage : pwgt_pkg

/* File: tb/pwgt_initiator_model.sv */
// initiator model: cpu, dma and coprocessor requests and protection instructions
`timescale 1ns/1ps
`default_nettype none
module pwgt_initiator_model
  import pwgt_pkg::*;
(
  // clock
  input wire logic core_clk_i,
  // protection instructions: cpu open, cpu close, cop open, cop close
  output logic [3:0] instr_o,
  // access request
  output logic req_valid_o,
  output logic req_write_o,
  output logic req_protected_o,
  output var pwgt_src_t req_src_o,
  output logic req_invalid_addr_o,
  output logic req_erased_flash_o,
  output logic [31:0] mem_rdata_o
);
  initial begin
    instr_o = 4'h0;
    {req_valid_o, req_write_o, req_protected_o} = 3'h0;
    {req_invalid_addr_o, req_erased_flash_o} = 2'h0;
    req_src_o = PWGT_SRC_CPU;
    mem_rdata_o = 32'h0;
  end
  // one pulse per executed instruction
  task automatic exec(input int k);
    @(posedge core_clk_i);
    instr_o <= 4'h1 << k;
    @(posedge core_clk_i);
    instr_o <= 4'h0;
  endtask
  task automatic access(input pwgt_src_t s, input logic w, p, i, e, input logic [31:0] d);
    @(posedge core_clk_i);
    req_valid_o <= 1'b1;
    req_write_o <= w;
    req_protected_o <= p;
    req_src_o <= s;
    {req_invalid_addr_o, req_erased_flash_o} <= {i, e};
    mem_rdata_o <= d;
    @(posedge core_clk_i);
    req_valid_o <= 1'b0;
    // released bus shows no stale word
    mem_rdata_o <= ~d;
  endtask
endmodule // pwgt_initiator_model
`default_nettype wire

/* File: tb/protected_write_gate_and_trap_bench.sv */
// self-checking bench for the protected write gate and fault trap
`timescale 1ns/1ps
`default_nettype none
module protected_write_gate_and_trap_bench;
  import pwgt_pkg::*;
  logic core_clk_i, resetn_i, rv, rw, rp, ri, re, pass, blk, rvalid, trap, irq, copen, kopen;
  logic [3:0] instr, cause;
  logic [8:0] ev;
  logic [31:0] md, fw, rdata;
  logic [2:0] diag;
  pwgt_src_t rs;
  int num_errors = 0;
  int n_checks = 0;
  pwgt_initiator_model i_init (.core_clk_i(core_clk_i), .instr_o(instr), .req_valid_o(rv),
    .req_write_o(rw), .req_protected_o(rp), .req_src_o(rs), .req_invalid_addr_o(ri),
    .req_erased_flash_o(re), .mem_rdata_o(md));
  pwgt_gate i_dut (.core_clk_i(core_clk_i), .resetn_i(resetn_i),
    .cpu_protect_write_open_i(instr[0]), .cpu_protect_write_close_i(instr[1]),
    .coproc_protect_write_open_i(instr[2]), .coproc_protect_write_close_i(instr[3]),
    .req_valid_i(rv), .req_write_i(rw), .req_protected_i(rp), .req_src_i(rs),
    .req_invalid_addr_i(ri), .req_erased_flash_i(re), .mem_rdata_i(md),
    .acc_pass_o(pass), .acc_blocked_o(blk), .rdata_o(rdata), .rvalid_o(rvalid),
    .cpu_fetch_valid_i(ev[0]), .cpu_fetch_word_i(fw), .cpu_underflow_i(ev[1]),
    .cpu_overflow_i(ev[2]), .cpu_illegal_op_i(ev[3]), .illegal_opcode_trap_o(trap),
    .cpu_diag_o(diag), .cop_fetch_valid_i(ev[4]), .cop_fetch_word_i(fw),
    .cop_illegal_op_i(ev[5]), .cop_underflow_i(ev[6]), .cop_overflow_i(ev[7]),
    .cop_cause_clear_i(ev[8]), .cop_irq_o(irq), .cop_cause_o(cause),
    .cpu_open_o(copen), .cop_open_o(kopen));
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic test_done();
    if (num_errors == 0 && n_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // pb is {pass, blocked}
  task automatic acc(input pwgt_src_t s, input logic w, p, i, e, input logic [31:0] d,
                     input logic [1:0] pb);
    i_init.access(s, w, p, i, e, d);
    @(negedge core_clk_i);
    chk("pass_blocked", {29'h0, rvalid, pass, blk}, {29'h0, !w, pb});
  endtask
  task automatic fire(input logic [8:0] e, input logic [31:0] w);
    @(posedge core_clk_i);
    ev <= e;
    fw <= w;
    @(posedge core_clk_i);
    ev <= 9'h0;
    fw <= ~w;
    @(negedge core_clk_i);
  endtask
  task automatic t_blocked();
    for (int s = 0; s < 3; s++) begin
      acc(pwgt_src_t'(s), 1'b1, 1'b1, 1'b0, 1'b0, 32'h0, 2'b01);
    end
    acc(PWGT_SRC_CPU, 1'b1, 1'b0, 1'b0, 1'b0, 32'h0, 2'b10);
    acc(PWGT_SRC_COPROC, 1'b0, 1'b1, 1'b0, 1'b0, 32'h5a5a_a5a5, 2'b10);
    chk("rdata", rdata, 32'h5a5a_a5a5);
  endtask
  task automatic t_flags();
    i_init.exec(0);
    @(negedge core_clk_i);
    @(negedge core_clk_i);
    chk("open_flags", {30'h0, kopen, copen}, 32'h1);
    acc(PWGT_SRC_DMA, 1'b1, 1'b1, 1'b0, 1'b0, 32'h0, 2'b10);
    acc(PWGT_SRC_CPU, 1'b1, 1'b1, 1'b0, 1'b0, 32'h0, 2'b10);
    acc(PWGT_SRC_COPROC, 1'b1, 1'b1, 1'b0, 1'b0, 32'h0, 2'b01);
    acc(pwgt_src_t'(2'h3), 1'b1, 1'b1, 1'b0, 1'b0, 32'h0, 2'b01);
    i_init.exec(1);
    acc(PWGT_SRC_DMA, 1'b1, 1'b1, 1'b0, 1'b0, 32'h0, 2'b01);
    i_init.exec(2);
    acc(PWGT_SRC_COPROC, 1'b1, 1'b1, 1'b0, 1'b0, 32'h0, 2'b10);
    acc(PWGT_SRC_CPU, 1'b1, 1'b1, 1'b0, 1'b0, 32'h0, 2'b01);
    i_init.exec(3);
    acc(PWGT_SRC_COPROC, 1'b1, 1'b1, 1'b0, 1'b0, 32'h0, 2'b01);
  endtask
  task automatic t_reset();
    i_init.exec(0);
    i_init.exec(2);
    @(negedge core_clk_i);
    @(negedge core_clk_i);
    chk("both_open", {30'h0, kopen, copen}, 32'h3);
    @(posedge core_clk_i);
    resetn_i <= 1'b0;
    repeat (5) @(posedge core_clk_i);
    resetn_i <= 1'b1;
    @(negedge core_clk_i);
    chk("reset_open", {30'h0, kopen, copen}, 32'h0);
    acc(PWGT_SRC_CPU, 1'b1, 1'b1, 1'b0, 1'b0, 32'h0, 2'b01);
    acc(PWGT_SRC_COPROC, 1'b1, 1'b1, 1'b0, 1'b0, 32'h0, 2'b01);
  endtask
  task automatic t_patterns();
    acc(PWGT_SRC_CPU, 1'b0, 1'b0, 1'b1, 1'b0, 32'h1234_5678, 2'b10);
    chk("rdata_invalid", rdata, PWGT_ZERO_WORD);
    acc(PWGT_SRC_DMA, 1'b0, 1'b0, 1'b0, 1'b1, 32'h1234_5678, 2'b10);
    chk("rdata_erased", rdata, PWGT_ONES_WORD);
    acc(PWGT_SRC_CPU, 1'b0, 1'b0, 1'b1, 1'b1, 32'h1234_5678, 2'b10);
    chk("rdata_both", rdata, PWGT_ZERO_WORD);
  endtask
  task automatic t_faults();
    fire(9'h001, PWGT_ZERO_WORD);
    chk("trap_zero", {31'h0, trap}, 32'h1);
    fire(9'h001, PWGT_ONES_WORD);
    chk("trap_ones", {31'h0, trap}, 32'h1);
    fire(9'h001, 32'h0000_1000);
    chk("trap_good", {31'h0, trap}, 32'h0);
    for (int k = 1; k < 4; k++) begin
      fire(9'h1 << k, 32'h0000_1000);
      chk("diag", {29'h0, diag}, (k == 3) ? 32'h1 : (32'h1 << k));
    end
    fire(9'h010, PWGT_ONES_WORD);
    chk("cause_irq", {27'h0, irq, cause}, 32'h18);
    fire(9'h000, 32'h0000_1000);
    chk("cause_hold", {27'h0, irq, cause}, 32'h18);
    fire(9'h100, 32'h0000_1000);
    chk("cause_clear", {27'h0, irq, cause}, 32'h0);
    fire(9'h010, 32'h0000_1000);
    chk("cause_good", {27'h0, irq, cause}, 32'h0);
    fire(9'h010, PWGT_ZERO_WORD);
    chk("cause_zero", {27'h0, irq, cause}, 32'h18);
    fire(9'h100, 32'h0000_1000);
    for (int k = 5; k < 8; k++) begin
      fire(9'h1 << k, 32'h0000_1000);
      chk("cop_fault", {27'h0, irq, cause}, 32'h10 | (32'h1 << (k - 5)));
      fire(9'h100, 32'h0000_1000);
    end
    fire(9'h020, 32'h0000_1000);
    chk("cause_ill", {27'h0, irq, cause}, 32'h11);
    fire(9'h140, 32'h0000_1000);
    chk("set_over_clear", {27'h0, irq, cause}, 32'h12);
  endtask
  initial begin
    core_clk_i = 1'b0;
    forever #5 core_clk_i = ~core_clk_i;
  end
  initial begin
    repeat (3000) @(posedge core_clk_i);
    num_errors++;
    test_done();
  end
  initial begin
    resetn_i = 1'b0;
    ev = 9'h0;
    fw = 32'h0;
    repeat (5) @(posedge core_clk_i);
    resetn_i <= 1'b1;
    @(negedge core_clk_i);
    chk("reset_flags", {28'h0, kopen, copen, pass, blk}, 32'h0);
    t_blocked();
    t_flags();
    t_reset();
    t_patterns();
    t_faults();
    test_done();
  end
endmodule // protected_write_gate_and_trap_bench
`default_nettype wire
